// >>> logic/load_bank_pkg.sv
// Constants and types shared by the command-object bank.
// Assumes a single 20 MHz clock and one request at a time.
package load_bank_pkg;

  // Object instances used on the request port
  localparam logic [15:0] INST_STATUS      = 16'h000d;
  localparam logic [15:0] INST_OUT_EN_WR   = 16'h000f;
  localparam logic [15:0] INST_OUT_EN_RD   = 16'h0010;
  localparam logic [15:0] INST_MEAS_CUR    = 16'h0101;
  localparam logic [15:0] INST_MEAS_VOLT   = 16'h0102;
  localparam logic [15:0] INST_MEAS_PWR    = 16'h0103;
  localparam logic [15:0] INST_CUR_TGT_WR  = 16'h0201;
  localparam logic [15:0] INST_CUR_TGT_RD  = 16'h0202;
  localparam logic [15:0] INST_VOLT_TGT_WR = 16'h0203;
  localparam logic [15:0] INST_VOLT_TGT_RD = 16'h0204;
  localparam logic [15:0] INST_PWR_TGT_WR  = 16'h0205;
  localparam logic [15:0] INST_PWR_TGT_RD  = 16'h0206;
  localparam logic [15:0] INST_CUR_HI_WR   = 16'h0301;
  localparam logic [15:0] INST_CUR_HI_RD   = 16'h0302;
  localparam logic [15:0] INST_VOLT_HI_WR  = 16'h0303;
  localparam logic [15:0] INST_VOLT_HI_RD  = 16'h0304;
  localparam logic [15:0] INST_PWR_HI_WR   = 16'h0305;
  localparam logic [15:0] INST_PWR_HI_RD   = 16'h0306;
  localparam logic [15:0] INST_VOLT_LO_WR  = 16'h0307;
  localparam logic [15:0] INST_VOLT_LO_RD  = 16'h0308;
  localparam logic [15:0] INST_CUR_UP_WR   = 16'h0401;
  localparam logic [15:0] INST_CUR_UP_RD   = 16'h0402;
  localparam logic [15:0] INST_VOLT_UP_WR  = 16'h0403;
  localparam logic [15:0] INST_VOLT_UP_RD  = 16'h0404;
  localparam logic [15:0] INST_PWR_UP_WR   = 16'h0405;
  localparam logic [15:0] INST_PWR_UP_RD   = 16'h0406;
  localparam logic [15:0] INST_CUR_DN_WR   = 16'h0409;
  localparam logic [15:0] INST_CUR_DN_RD   = 16'h040a;

  // Second status word field positions
  localparam int ST_PHASE_MISSING = 0;
  localparam int ST_FUSE_OPEN     = 1;
  localparam int ST_FAN_STALL     = 2;
  localparam int ST_TEMP_LO       = 4;
  localparam int ST_BAD_RATING    = 16;
  localparam int ST_FW_MISMATCH   = 17;

  // Trip order inside the trip vectors
  localparam int TRIP_CUR_HI  = 0;
  localparam int TRIP_VOLT_HI = 1;
  localparam int TRIP_PWR_HI  = 2;
  localparam int TRIP_VOLT_LO = 3;

  // Consecutive out-of-range samples before a trip
  localparam logic [2:0] TRIP_SAMPLES = 3'h4;

  // Slew clamp bounds and reset values (IEEE single)
  localparam logic [31:0] SLEW_MIN     = 32'h3c23d70a; // 0.01
  localparam logic [31:0] SLEW_MAX     = 32'h447a0000; // 1000.0
  localparam logic [31:0] TGT_RESET    = 32'h00000000;
  localparam logic [31:0] HI_LIM_RESET = 32'h7f7fffff; // largest float
  localparam logic [31:0] LO_LIM_RESET = 32'h00000000;

  // Slew keywords carried with a Set request
  localparam logic [1:0] KW_NONE    = 2'h0;
  localparam logic [1:0] KW_FASTEST = 2'h1;
  localparam logic [1:0] KW_SLOWEST = 2'h2;

  // Regulation modes reported by the control loop
  localparam logic [1:0] MODE_CC = 2'h0;
  localparam logic [1:0] MODE_CV = 2'h1;
  localparam logic [1:0] MODE_CP = 2'h2;

  typedef enum logic [0:0] {RSP_IDLE, RSP_WORD1} rsp_phase_e;

endpackage

// >>> logic/load_command_object_bank.sv
// Command-object bank: set-points, trip limits, slew settings,
// averaged readings and the second live status word.
// Assumes requests and readings come from logic on clk; the nine
// fault inputs come from pins and are synchronised here.
//
// Notes on behaviour
// - Status bits 0,1,2,16,17 carry system faults
// - Status bits 4..7 carry temperature faults
// - Status at 13 is live, two words, unlatched
// - Output enable: write 15, read 16
// - Get 257 returns averaged current
// - Get 258 returns voltage, sense when remote
// - Get 259 returns averaged power
// - Current target: write 513, read 514
// - Voltage target: write 515, read 516
// - Power target: write 517, read 518
// - Current high limit 769/770, trips input
// - Voltage high limit 771/772, trips input
// - Power high limit 773/774, trips input
// - Voltage low limit 775/776, trips input
// - Current rise slew 1025/1026, CC only
// - Voltage rise slew 1027/1028, CV only
// - Power rise slew 1029/1030, CP only
// - Current fall slew 1033/1034, CC only
// - Slew keywords and clamping to bounds
`timescale 1ns/10ps
module load_command_object_bank
  import load_bank_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request port
  input  wire logic        req_valid,
  input  wire logic        req_set,
  input  wire logic [15:0] req_instance,
  input  wire logic [31:0] req_data,
  input  wire logic [1:0]  req_keyword,
  // Answer port
  output logic             rsp_valid,
  output logic             rsp_last,
  output logic             rsp_error,
  output logic [31:0]      rsp_data,
  // Averaged readings from the measurement path
  input  wire logic        meas_valid,
  input  wire logic [31:0] meas_current,
  input  wire logic [31:0] meas_voltage,
  input  wire logic [31:0] meas_power,
  input  wire logic [31:0] sense_voltage,
  input  wire logic        sense_remote,
  // Regulation state and first status word
  input  wire logic [1:0]  reg_mode,
  input  wire logic [31:0] status_word0,
  // Fault pins, asynchronous
  input  wire logic        phase_missing_flag,
  input  wire logic        input_fuse_open_flag,
  input  wire logic        fan_stall_flag,
  input  wire logic        power_stage_overtemp,
  input  wire logic        output_filter_overtemp,
  input  wire logic        output_cap_overtemp,
  input  wire logic        transformer_overtemp,
  input  wire logic        bad_system_rating_flag,
  input  wire logic        firmware_mismatch_flag,
  // Power stage controls
  output logic             output_enable,
  output logic             input_disconnect,
  output logic [3:0]       trip_flags,
  output logic [31:0]      active_target,
  output logic [31:0]      active_rise_slew,
  output logic [31:0]      active_fall_slew
);

  typedef struct packed {
    // Fault pins, two synchroniser stages
    logic [8:0]       pin_meta;
    logic [8:0]       pin_sync;

    // Output enable, disconnect and sticky trips
    logic             out_en;
    logic             disc;
    logic [3:0]       trip;
    logic [3:0][2:0]  cnt;

    // Values held for the host
    logic [31:0]      cur_tgt;
    logic [31:0]      volt_tgt;
    logic [31:0]      pwr_tgt;
    logic [3:0][31:0] lim;
    logic [31:0]      cur_up;
    logic [31:0]      volt_up;
    logic [31:0]      pwr_up;
    logic [31:0]      cur_dn;

    // Second status beat, captured with the first
    logic [31:0]      stat1_hold;
    rsp_phase_e       phase;

    // Registered answer port
    logic             rv;
    logic             rl;
    logic             re;
    logic [31:0]      rd;

    // Values in force for the present mode
    logic [31:0]      act_tgt;
    logic [31:0]      act_up;
    logic [31:0]      act_dn;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Maps a float to a key whose unsigned order is numeric order
  // Negative floats flip every bit; NaN has no defined place
  function automatic logic [31:0] fkey(input logic [31:0] f);
    fkey = f[31] ? ~f : (f | 32'h80000000);
  endfunction

  function automatic logic fgt(input logic [31:0] a,
                               input logic [31:0] b);
    fgt = fkey(a) > fkey(b);
  endfunction

  // Slew write: keywords pick a bound, others clamp into range
  function automatic logic [31:0] slew_val(input logic [31:0] v,
                                           input logic [1:0]  kw);
    if (kw == KW_FASTEST) begin
      slew_val = SLEW_MAX;
    end else if (kw == KW_SLOWEST) begin
      slew_val = SLEW_MIN;
    end else if (fgt(SLEW_MIN, v)) begin
      slew_val = SLEW_MIN;
    end else if (fgt(v, SLEW_MAX)) begin
      slew_val = SLEW_MAX;
    end else begin
      slew_val = v;
    end
  endfunction

  // Combinational helpers, all on clk
  logic [31:0] volt_rpt;
  logic [31:0] stat1;
  logic [3:0]  over;
  logic        wr;
  logic        rd;
  logic        hit;

  // Reported voltage follows the sense terminals when remote
  assign volt_rpt = sense_remote ? sense_voltage : meas_voltage;

  // Second status word; unused positions are hard zero
  always_comb begin
    stat1 = 32'h00000000;
    stat1[ST_PHASE_MISSING] = st_reg.pin_sync[0];
    stat1[ST_FUSE_OPEN]     = st_reg.pin_sync[1];
    stat1[ST_FAN_STALL]     = st_reg.pin_sync[2];
    stat1[ST_TEMP_LO+3:ST_TEMP_LO] = st_reg.pin_sync[6:3];
    stat1[ST_BAD_RATING]    = st_reg.pin_sync[7];
    stat1[ST_FW_MISMATCH]   = st_reg.pin_sync[8];
  end

  // Out-of-range test for each trip on the present sample
  always_comb begin
    over = 4'h0;
    over[TRIP_CUR_HI]  = fgt(meas_current, st_reg.lim[TRIP_CUR_HI]);
    over[TRIP_VOLT_HI] = fgt(volt_rpt, st_reg.lim[TRIP_VOLT_HI]);
    over[TRIP_PWR_HI]  = fgt(meas_power, st_reg.lim[TRIP_PWR_HI]);
    over[TRIP_VOLT_LO] = fgt(st_reg.lim[TRIP_VOLT_LO], volt_rpt);
  end

  // Nothing is taken while the second status beat is due
  assign wr = req_valid && req_set && (st_reg.phase == RSP_IDLE);
  assign rd = req_valid && !req_set && (st_reg.phase == RSP_IDLE);

  // Next-state logic for the whole bank
  always_comb begin
    st_next = st_reg;
    hit     = 1'b1;
    // Fault pins cross into clk through two flops
    st_next.pin_meta = {firmware_mismatch_flag, bad_system_rating_flag,
                        transformer_overtemp, output_cap_overtemp,
                        output_filter_overtemp, power_stage_overtemp,
                        fan_stall_flag, input_fuse_open_flag,
                        phase_missing_flag};
    st_next.pin_sync = st_reg.pin_meta;
    st_next.rv = 1'b0;
    st_next.rl = 1'b0;
    st_next.re = 1'b0;
    st_next.rd = 32'h00000000;

    // Set services; a Set at a read instance is refused
    if (wr) begin
      unique case (req_instance)
        INST_OUT_EN_WR: begin
          st_next.out_en = req_data[0];
          if (req_data[0]) begin
            st_next.trip = 4'h0;
            st_next.disc = 1'b0;
          end
        end

        // Targets and limits are stored exactly as written
        INST_CUR_TGT_WR:  st_next.cur_tgt = req_data;
        INST_VOLT_TGT_WR: st_next.volt_tgt = req_data;
        INST_PWR_TGT_WR:  st_next.pwr_tgt = req_data;
        INST_CUR_HI_WR:   st_next.lim[TRIP_CUR_HI] = req_data;
        INST_VOLT_HI_WR:  st_next.lim[TRIP_VOLT_HI] = req_data;
        INST_PWR_HI_WR:   st_next.lim[TRIP_PWR_HI] = req_data;
        INST_VOLT_LO_WR:  st_next.lim[TRIP_VOLT_LO] = req_data;

        // Slews pass the keyword and clamp stage first
        INST_CUR_UP_WR:
          st_next.cur_up = slew_val(req_data, req_keyword);
        INST_VOLT_UP_WR:
          st_next.volt_up = slew_val(req_data, req_keyword);
        INST_PWR_UP_WR:
          st_next.pwr_up = slew_val(req_data, req_keyword);
        INST_CUR_DN_WR:
          st_next.cur_dn = slew_val(req_data, req_keyword);
        default: hit = 1'b0;
      endcase
      st_next.rv = 1'b1;
      st_next.rl = 1'b1;
      st_next.re = !hit;
    end

    // Get services; status takes two beats, word 0 first
    if (rd) begin
      unique case (req_instance)
        INST_STATUS: begin
          st_next.rd = status_word0;
          st_next.stat1_hold = stat1;
          st_next.phase = RSP_WORD1;
        end
        INST_OUT_EN_RD:   st_next.rd = {31'h0, st_reg.out_en};

        // Readings are taken at the request edge
        INST_MEAS_CUR:    st_next.rd = meas_current;
        INST_MEAS_VOLT:   st_next.rd = volt_rpt;
        INST_MEAS_PWR:    st_next.rd = meas_power;

        // Stored values read back unchanged
        INST_CUR_TGT_RD:  st_next.rd = st_reg.cur_tgt;
        INST_VOLT_TGT_RD: st_next.rd = st_reg.volt_tgt;
        INST_PWR_TGT_RD:  st_next.rd = st_reg.pwr_tgt;
        INST_CUR_HI_RD:   st_next.rd = st_reg.lim[TRIP_CUR_HI];
        INST_VOLT_HI_RD:  st_next.rd = st_reg.lim[TRIP_VOLT_HI];
        INST_PWR_HI_RD:   st_next.rd = st_reg.lim[TRIP_PWR_HI];
        INST_VOLT_LO_RD:  st_next.rd = st_reg.lim[TRIP_VOLT_LO];
        INST_CUR_UP_RD:   st_next.rd = st_reg.cur_up;
        INST_VOLT_UP_RD:  st_next.rd = st_reg.volt_up;
        INST_PWR_UP_RD:   st_next.rd = st_reg.pwr_up;
        INST_CUR_DN_RD:   st_next.rd = st_reg.cur_dn;
        default:          hit = 1'b0;
      endcase
      st_next.rv = 1'b1;
      st_next.rl = (req_instance != INST_STATUS);
      st_next.re = !hit;
    end

    // Second beat of a status read; no bit is cleared by it
    if (st_reg.phase == RSP_WORD1) begin
      st_next.rv    = 1'b1;
      st_next.rl    = 1'b1;
      st_next.rd    = st_reg.stat1_hold;
      st_next.phase = RSP_IDLE;
    end

    // Trip qualification: count consecutive bad samples
    // The count saturates so it cannot wrap below the trip point
    if (meas_valid) begin
      for (int i = 0; i < 4; i++) begin
        if (!over[i]) begin
          st_next.cnt[i] = 3'h0;
        end else if (st_reg.cnt[i] != TRIP_SAMPLES) begin
          st_next.cnt[i] = st_reg.cnt[i] + 3'h1;
        end
        // Set wins over a clear written in the same cycle; a fault
        // that outlasts a re-enable trips again on its next sample
        if (over[i] && (st_reg.cnt[i] >= TRIP_SAMPLES - 3'h1)) begin
          st_next.trip[i] = 1'b1;
          st_next.disc    = 1'b1;
          st_next.out_en  = 1'b0;
        end
      end
    end

    // Regulation mode picks which target and slews are in force
    // CV and CP have no falling slew of their own in this block
    unique case (reg_mode)
      MODE_CC: begin
        st_next.act_tgt = st_reg.cur_tgt;
        st_next.act_up  = st_reg.cur_up;
        st_next.act_dn  = st_reg.cur_dn;
      end

      MODE_CV: begin
        st_next.act_tgt = st_reg.volt_tgt;
        st_next.act_up  = st_reg.volt_up;
        st_next.act_dn  = SLEW_MAX;
      end

      MODE_CP: begin
        st_next.act_tgt = st_reg.pwr_tgt;
        st_next.act_up  = st_reg.pwr_up;
        st_next.act_dn  = SLEW_MAX;
      end

      default: begin
        // Unknown mode: hold safe zero target, fastest slews
        st_next.act_tgt = TGT_RESET;
        st_next.act_up  = SLEW_MAX;
        st_next.act_dn  = SLEW_MAX;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Pins read as clear until two edges after release
      st_reg.pin_meta   <= 9'h000;
      st_reg.pin_sync   <= 9'h000;
      st_reg.out_en     <= 1'b0;
      st_reg.disc       <= 1'b0;
      st_reg.trip       <= 4'h0;
      st_reg.cnt        <= '0;

      // Targets idle at zero, limits wide open, slews fastest
      st_reg.cur_tgt    <= TGT_RESET;
      st_reg.volt_tgt   <= TGT_RESET;
      st_reg.pwr_tgt    <= TGT_RESET;
      st_reg.lim[TRIP_CUR_HI]  <= HI_LIM_RESET;
      st_reg.lim[TRIP_VOLT_HI] <= HI_LIM_RESET;
      st_reg.lim[TRIP_PWR_HI]  <= HI_LIM_RESET;
      st_reg.lim[TRIP_VOLT_LO] <= LO_LIM_RESET;
      st_reg.cur_up     <= SLEW_MAX;
      st_reg.volt_up    <= SLEW_MAX;
      st_reg.pwr_up     <= SLEW_MAX;
      st_reg.cur_dn     <= SLEW_MAX;

      // Answer port quiet, no beat pending
      st_reg.stat1_hold <= 32'h00000000;
      st_reg.phase      <= RSP_IDLE;
      st_reg.rv         <= 1'b0;
      st_reg.rl         <= 1'b0;
      st_reg.re         <= 1'b0;
      st_reg.rd         <= 32'h00000000;
      st_reg.act_tgt    <= TGT_RESET;
      st_reg.act_up     <= SLEW_MAX;
      st_reg.act_dn     <= SLEW_MAX;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign rsp_valid        = st_reg.rv;
  assign rsp_last         = st_reg.rl;
  assign rsp_error        = st_reg.re;
  assign rsp_data         = st_reg.rd;

  // Power stage controls
  assign output_enable    = st_reg.out_en;
  assign input_disconnect = st_reg.disc;
  assign trip_flags       = st_reg.trip;
  assign active_target    = st_reg.act_tgt;
  assign active_rise_slew = st_reg.act_up;
  assign active_fall_slew = st_reg.act_dn;

endmodule

// >>> testbench/load_bank_assertions.sv
// Checker for the bank's answer and trip behaviour.
// Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/10ps
module load_bank_checker
  import load_bank_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Request and answer
  input wire logic        req_valid,
  input wire logic        req_set,
  input wire logic [15:0] req_instance,
  input wire logic        rsp_valid,
  input wire logic        rsp_last,
  input wire logic        rsp_error,
  input wire logic [31:0] rsp_data,
  // Readings and trip outputs
  input wire logic        meas_valid,
  input wire logic [31:0] meas_current,
  input wire logic [31:0] sense_voltage,
  input wire logic        sense_remote,
  input wire logic        output_enable,
  input wire logic        input_disconnect,
  input wire logic [3:0]  trip_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Request decodes shared by several properties
  logic get_rq;
  logic get_st;
  assign get_rq = req_valid && !req_set;
  assign get_st = get_rq && req_instance == INST_STATUS;

  a_status_beats: assert property (
    get_st |=> rsp_valid && !rsp_last ##1 rsp_valid && rsp_last)
    else $error("status answer is not two beats");
  a_status_unused: assert property (
    get_st |=> ##1 (rsp_data & 32'hfffcff08) == 32'h0)
    else $error("unused status bit set");
  a_set_ack: assert property (
    req_valid && req_set && req_instance == INST_CUR_TGT_WR
    |=> rsp_valid && rsp_last && !rsp_error && rsp_data == 32'h0)
    else $error("set answer wrong");
  a_wrong_service: assert property (
    get_rq && req_instance == INST_CUR_TGT_WR |=> rsp_valid && rsp_error)
    else $error("get on write instance not refused");
  a_cur_reading: assert property (
    get_rq && req_instance == INST_MEAS_CUR
    |=> rsp_data == $past(meas_current))
    else $error("current reading wrong");
  a_sense_volt: assert property (
    get_rq && req_instance == INST_MEAS_VOLT && sense_remote
    |=> rsp_data == $past(sense_voltage))
    else $error("sense voltage not returned");
  a_trip_cutoff: assert property (
    $rose(input_disconnect) |-> !output_enable && trip_flags != 4'h0)
    else $error("trip left output on");
  a_trip_sample: assert property (
    $rose(input_disconnect) |-> $past(meas_valid))
    else $error("trip without a sample");

  // Main scenarios reached
  c_status: cover property (get_st ##2 rsp_valid && rsp_last);
  c_trip: cover property ($rose(input_disconnect));
  c_error: cover property (rsp_valid && rsp_error);
endmodule

bind load_command_object_bank load_bank_checker chk_u (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req_set(req_set),
  .req_instance(req_instance), .rsp_valid(rsp_valid),
  .rsp_last(rsp_last), .rsp_error(rsp_error), .rsp_data(rsp_data),
  .meas_valid(meas_valid), .meas_current(meas_current),
  .sense_voltage(sense_voltage), .sense_remote(sense_remote),
  .output_enable(output_enable), .input_disconnect(input_disconnect),
  .trip_flags(trip_flags));

// >>> testbench/bus_controller_model.sv
// Remote controller model: one Set or Get at a time.
// Assumes answers arrive within eight cycles on rsp_valid.
`timescale 1ns/10ps
module bus_controller_model (
  // Clock
  input  wire logic        clk,
  // Request side
  output logic             req_valid,
  output logic             req_set,
  output logic [15:0]      req_instance,
  output logic [31:0]      req_data,
  output logic [1:0]       req_keyword,
  // Answer side
  input  wire logic        rsp_valid,
  input  wire logic        rsp_last,
  input  wire logic        rsp_error,
  input  wire logic [31:0] rsp_data
);
  // Idle values at time zero
  initial begin
    req_valid = 1'b0;
    req_set = 1'b0;
    req_instance = 16'h0;
    req_data = 32'h0;
    req_keyword = 2'h0;
  end

  // One-cycle request, then wait for the answer beat; data is
  // inverted on release so a stale value is never mistaken for live
  task automatic xfer(input logic s, input logic [15:0] i,
    input logic [31:0] d, input logic [1:0] k,
    output logic [31:0] q, output logic e, output logic l);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_set = s;
    req_instance = i;
    req_data = d;
    req_keyword = k;
    @(negedge clk);
    req_valid = 1'b0;
    req_data = ~d;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    q = (n < 8) ? rsp_data : 32'hxxxxxxxx;
    e = rsp_error;
    l = rsp_last;
  endtask

  // Second beat of a status answer; caller then idles a cycle
  task automatic next_beat(output logic [31:0] q, output logic l);
    @(negedge clk);
    q = rsp_data;
    l = rsp_valid & rsp_last;
  endtask
endmodule

// >>> testbench/load_command_object_bank_tb.sv
// Testbench for the command-object bank: requests go through the
// controller model; readings and fault pins are driven here.
`timescale 1ns/10ps
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
  fail_count++; $display("wrong value %s exp %h got %h", n, x, g); end end
module load_command_object_bank_tb import load_bank_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, req_set, rsp_valid, rsp_last, rsp_error, e, l;
  logic [15:0] req_instance;
  logic [31:0] req_data, rsp_data, q;
  logic [1:0] req_keyword;
  logic meas_valid = 1'b0;
  logic sense_remote = 1'b0;
  logic [31:0] meas_current = 32'h3f800000;
  logic [31:0] meas_voltage = 32'h3f800000;
  logic [31:0] meas_power = 32'h3f800000;
  logic [31:0] sense_voltage = 32'h3fe00000;
  logic [31:0] status_word0 = 32'h12345678;
  logic [1:0] reg_mode = MODE_CC;
  logic [8:0] flt = 9'h000;
  logic output_enable, input_disconnect;
  logic [3:0] trip_flags;
  logic [31:0] active_target, active_rise_slew, active_fall_slew;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Write instances; each read instance is the next number
  logic [15:0] wi [11] = '{INST_CUR_TGT_WR, INST_VOLT_TGT_WR,
    INST_PWR_TGT_WR, INST_CUR_HI_WR, INST_VOLT_HI_WR, INST_PWR_HI_WR,
    INST_VOLT_LO_WR, INST_CUR_UP_WR, INST_VOLT_UP_WR, INST_PWR_UP_WR,
    INST_CUR_DN_WR};
  logic [31:0] rv [11] = '{TGT_RESET, TGT_RESET, TGT_RESET,
    HI_LIM_RESET, HI_LIM_RESET, HI_LIM_RESET, LO_LIM_RESET,
    SLEW_MAX, SLEW_MAX, SLEW_MAX, SLEW_MAX};
  logic [31:0] wv [11] = '{32'h41200000, 32'h41a00000, 32'h42c80000,
    32'h40000000, 32'h40000000, 32'h40000000, 32'h3f000000,
    32'h3f800000, 32'h40000000, 32'h40400000, 32'h40800000};
  logic [31:0] rs [3] = '{SLEW_MIN, SLEW_MAX, SLEW_MIN};
  logic [31:0] fs [3] = '{SLEW_MIN, SLEW_MAX, SLEW_MAX};
  logic [5:0] stage_out;
  assign stage_out = {trip_flags, input_disconnect, output_enable};

  bus_controller_model bus_u (.clk(clk), .req_valid(req_valid),
    .req_set(req_set), .req_instance(req_instance),
    .req_data(req_data), .req_keyword(req_keyword),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last),
    .rsp_error(rsp_error), .rsp_data(rsp_data));

  load_command_object_bank dut_u (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_set(req_set),
    .req_instance(req_instance), .req_data(req_data),
    .req_keyword(req_keyword), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_error(rsp_error), .rsp_data(rsp_data),
    .meas_valid(meas_valid), .meas_current(meas_current),
    .meas_voltage(meas_voltage), .meas_power(meas_power),
    .sense_voltage(sense_voltage), .sense_remote(sense_remote),
    .reg_mode(reg_mode), .status_word0(status_word0),
    .phase_missing_flag(flt[0]), .input_fuse_open_flag(flt[1]),
    .fan_stall_flag(flt[2]), .power_stage_overtemp(flt[3]),
    .output_filter_overtemp(flt[4]), .output_cap_overtemp(flt[5]),
    .transformer_overtemp(flt[6]), .bad_system_rating_flag(flt[7]),
    .firmware_mismatch_flag(flt[8]), .output_enable(output_enable),
    .input_disconnect(input_disconnect), .trip_flags(trip_flags),
    .active_target(active_target),
    .active_rise_slew(active_rise_slew),
    .active_fall_slew(active_fall_slew));

  // 20 MHz clock and a hang guard well above the test length
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Access tasks: Set answers carry no error and zero data
  task automatic wr(input logic [15:0] i, input logic [31:0] d,
    input logic [1:0] k);
    bus_u.xfer(1'b1, i, d, k, q, e, l);
    `CHK("set answer", 34'h000000001, {e, q, l})
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] x);
    bus_u.xfer(1'b0, i, 32'h0, KW_NONE, q, e, l);
    `CHK("get data", {1'b0, x, 1'b1}, {e, q, l})
  endtask
  task automatic bad(input logic s, input logic [15:0] i);
    bus_u.xfer(s, i, 32'h0, KW_NONE, q, e, l);
    `CHK("refusal", 34'h200000001, {e, q, l})
  endtask
  // Status read; second word worked out from the fault pins
  task automatic stat();
    bus_u.xfer(1'b0, INST_STATUS, 32'h0, KW_NONE, q, e, l);
    `CHK("status word0", {status_word0, 1'b0}, {q, l})
    bus_u.next_beat(q, l);
    `CHK("status word1", {14'h0, flt[8:7], 8'h0, flt[6:3], 1'b0,
      flt[2:0], 1'b1}, {q, l})
  endtask
  // Readings for trip k, out of range when b is set
  task automatic load(input int k, input logic b);
    meas_current = (b && k == 0) ? 32'h40800000 : 32'h3f800000;
    meas_voltage = (b && k == 1) ? 32'h40800000 :
      (b && k == 3) ? 32'h3e800000 : 32'h3f800000;
    meas_power = (b && k == 2) ? 32'h40800000 : 32'h3f800000;
  endtask
  task automatic samp(input int n);
    repeat (n) begin
      @(negedge clk);
      meas_valid = 1'b1;
      @(negedge clk);
      meas_valid = 1'b0;
    end
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd(INST_OUT_EN_RD, 32'h0);
    for (int j = 0; j < 11; j++) begin
      rd(wi[j] + 16'h1, rv[j]);
      wr(wi[j], wv[j], KW_NONE);
      rd(wi[j] + 16'h1, wv[j]);
    end
    wr(INST_CUR_UP_WR, 32'h00000000, KW_NONE);
    rd(INST_CUR_UP_RD, SLEW_MIN);
    wr(INST_VOLT_UP_WR, 32'h7f7fffff, KW_NONE);
    rd(INST_VOLT_UP_RD, SLEW_MAX);
    wr(INST_PWR_UP_WR, 32'h3f800000, KW_SLOWEST);
    rd(INST_PWR_UP_RD, SLEW_MIN);
    wr(INST_CUR_DN_WR, 32'h3f800000, KW_FASTEST);
    rd(INST_CUR_DN_RD, SLEW_MAX);
    wr(INST_CUR_DN_WR, 32'h3f800000, KW_SLOWEST);
    rd(INST_CUR_DN_RD, SLEW_MIN);
    for (int m = 0; m < 3; m++) begin
      reg_mode = 2'(m);
      repeat (3) @(negedge clk);
      `CHK("target", wv[m], active_target)
      `CHK("rise slew", rs[m], active_rise_slew)
      `CHK("fall slew", fs[m], active_fall_slew)
    end
    reg_mode = MODE_CC;
    bad(1'b0, INST_CUR_TGT_WR);
    bad(1'b1, INST_CUR_TGT_RD);
    bad(1'b1, INST_STATUS);
    bad(1'b0, 16'h0999);
    rd(INST_CUR_TGT_RD, wv[0]);
    meas_current = 32'h3fc00000;
    meas_voltage = 32'h3fa00000;
    meas_power = 32'h3f900000;
    rd(INST_MEAS_CUR, meas_current);
    rd(INST_MEAS_VOLT, meas_voltage);
    rd(INST_MEAS_PWR, meas_power);
    sense_remote = 1'b1;
    rd(INST_MEAS_VOLT, sense_voltage);
    sense_remote = 1'b0;
    flt = 9'h1ff;
    repeat (3) @(negedge clk);
    stat();
    flt = 9'h0a5;
    repeat (3) @(negedge clk);
    stat();
    stat();
    wr(INST_OUT_EN_WR, 32'h1, KW_NONE);
    rd(INST_OUT_EN_RD, 32'h1);
    for (int k = 0; k < 4; k++) begin
      load(k, 1'b1);
      samp(3);
      load(k, 1'b0);
      samp(1);
      load(k, 1'b1);
      samp(3);
      `CHK("early trip", 1'b0, input_disconnect)
      samp(1);
      @(negedge clk);
      `CHK("trip", {4'h1 << k, 2'b10}, stage_out)
      rd(INST_OUT_EN_RD, 32'h0);
      load(k, 1'b0);
      wr(INST_OUT_EN_WR, 32'h1, KW_NONE);
      `CHK("trip clear", 6'h01, stage_out)
    end
    conclude();
  end
endmodule
